// ### rtl/rfl_pkg.sv
// ----------------------------------------------------------------------
// Shared constants of the CPU register file
// ----------------------------------------------------------------------
package rfl_pkg;

  // Widths of the register set
  localparam int DATA_W = 16;
  localparam int ADDR20_W = 20;
  localparam int FLAG_W = 11;
  localparam int IDX_W = 5;
  localparam int BANK_REGS = 7;
  localparam int SLOT_W = 3;
  localparam int BANK_COUNT = 2;

  // Register port indices
  localparam logic [4:0] IDX_DATA_ZERO = 5'h00;
  localparam logic [4:0] IDX_DATA_ONE = 5'h01;
  localparam logic [4:0] IDX_DATA_TWO = 5'h02;
  localparam logic [4:0] IDX_DATA_THREE = 5'h03;
  localparam logic [4:0] IDX_ADDR_FIRST = 5'h04;
  localparam logic [4:0] IDX_ADDR_SECOND = 5'h05;
  localparam logic [4:0] IDX_FRAME_BASE = 5'h06;
  localparam logic [4:0] IDX_STATIC_BASE = 5'h07;
  localparam logic [4:0] IDX_VECTOR_BASE = 5'h08;
  localparam logic [4:0] IDX_PROG_COUNT = 5'h09;
  localparam logic [4:0] IDX_USER_SP = 5'h0a;
  localparam logic [4:0] IDX_INTR_SP = 5'h0b;
  localparam logic [4:0] IDX_FLAGS = 5'h0c;
  localparam logic [4:0] IDX_ACTIVE_SP = 5'h0d;
  localparam logic [4:0] IDX_ZERO_LOW = 5'h0e;
  localparam logic [4:0] IDX_ZERO_HIGH = 5'h0f;
  localparam logic [4:0] IDX_ONE_LOW = 5'h10;
  localparam logic [4:0] IDX_ONE_HIGH = 5'h11;
  localparam logic [4:0] IDX_PAIR_LOW32 = 5'h12;
  localparam logic [4:0] IDX_PAIR_HIGH32 = 5'h13;
  localparam logic [4:0] IDX_ADDR_PAIR32 = 5'h14;

  // Slots inside one register bank
  localparam logic [2:0] SLOT_D0 = 3'h0;
  localparam logic [2:0] SLOT_D1 = 3'h1;
  localparam logic [2:0] SLOT_D2 = 3'h2;
  localparam logic [2:0] SLOT_D3 = 3'h3;
  localparam logic [2:0] SLOT_A0 = 3'h4;
  localparam logic [2:0] SLOT_A1 = 3'h5;
  localparam logic [2:0] SLOT_FB = 3'h6;

  // Flag register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;

  // Reset values
  localparam logic [10:0] FLG_RESET = 11'h000;
  localparam logic [19:0] PC_RESET = 20'h00000;
  localparam logic [19:0] VECTOR_TABLE_BASE_RESET = 20'h00000;
  localparam logic [15:0] REG16_RESET = 16'h0000;

  // Byte lane enables
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  // Operand size of an ALU result
  typedef enum logic [1:0] {
    RFL_SZ_BYTE = 2'h0,
    RFL_SZ_WORD = 2'h1,
    RFL_SZ_LONG = 2'h2
  } rfl_size_e;

endpackage : rfl_pkg

// ### rtl/rfl_bank.sv
`timescale 1ns/1ns
// One register bank: data, address and frame base registers
module rfl_bank #(
  parameter int N = 7,
  parameter int W = 16,
  parameter int XW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // First write port, with byte lanes
  input wire logic a_we,
  input wire logic [XW-1:0] a_idx,
  input wire logic [1:0] a_be,
  input wire logic [W-1:0] a_data,
  // Second write port, upper half of a pair
  input wire logic b_we,
  input wire logic [XW-1:0] b_idx,
  input wire logic [W-1:0] b_data,
  // All registers, slot 0 lowest
  output logic [N*W-1:0] regs_flat
);
  import rfl_pkg::*;

  // Bank state
  typedef struct packed {
    logic [N-1:0][W-1:0] r;
  } rfl_bank_s;

  rfl_bank_s st_r;
  rfl_bank_s st_nxt;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Byte lanes merge into the held word; the pair port writes whole words
  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++)
    begin
      if (a_we && (a_idx == XW'(i)))
      begin
        if (a_be[0])
          st_nxt.r[i][W/2-1:0] = a_data[W/2-1:0];
        if (a_be[1])
          st_nxt.r[i][W-1:W/2] = a_data[W-1:W/2];
      end
      if (b_we && (b_idx == XW'(i)))
        st_nxt.r[i] = b_data;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign regs_flat = st_r.r;

endmodule : rfl_bank

// ### rtl/rfl_flag_calc.sv
`timescale 1ns/1ns
// Condition flags from one ALU result
module rfl_flag_calc (
  // ALU outcome
  input wire logic [31:0] result,
  input wire rfl_pkg::rfl_size_e size,
  input wire logic carry_in,
  input wire logic ovf_in,
  // Derived flags
  output logic zero_f,
  output logic sign_f,
  output logic carry_f,
  output logic ovf_f
);
  import rfl_pkg::*;

  // ----------------------------------------------------------------------
  // Flag derivation
  // ----------------------------------------------------------------------
  // Zero and sign look only at the bits of the operand size
  always_comb
  begin
    carry_f = carry_in; // RULE9
    ovf_f = ovf_in; // RULE14
    unique case (size)
      RFL_SZ_BYTE:
      begin
        zero_f = (result[7:0] == 8'h00); // RULE11
        sign_f = result[7]; // RULE12
      end
      RFL_SZ_WORD:
      begin
        zero_f = (result[15:0] == 16'h0000); // RULE11
        sign_f = result[15]; // RULE12
      end
      RFL_SZ_LONG:
      begin
        zero_f = (result == 32'h00000000); // RULE11
        sign_f = result[31]; // RULE12
      end
      default:
      begin
        zero_f = (result[15:0] == 16'h0000);
        sign_f = result[15];
      end
    endcase
  end

endmodule : rfl_flag_calc

// ### rtl/rfl_core.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// [RULE1] Four 16-bit data registers, two byte-split
// [RULE2] Data registers pair into two 32-bit registers
// [RULE3] Two 16-bit address registers, pairable to 32
// [RULE4] Separate 16-bit frame and static bases
// [RULE5] 20-bit vector table base register
// [RULE6] 20-bit program counter, next instruction address
// [RULE7] User and interrupt stack, flag selects
// [RULE8] 11-bit flag register shows processor state
// [RULE9] Carry flag captures ALU carry out
// [RULE10] Software keeps debug flag at zero
// [RULE11] Zero flag set on zero result
// [RULE12] Sign flag set on negative result
// [RULE13] Bank flag picks register bank
// [RULE14] Overflow flag follows operation overflow
// [RULE15] Each bank fully duplicates its registers
module rfl_core (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register access port
  input wire logic [rfl_pkg::IDX_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // ALU flag update
  input wire logic alu_upd,
  input wire logic [31:0] alu_result,
  input wire rfl_pkg::rfl_size_e alu_size,
  input wire logic alu_carry,
  input wire logic alu_ovf,
  // Program counter sequencing
  input wire logic pc_adv,
  input wire logic [2:0] pc_step,
  // Live processor state
  output logic [rfl_pkg::ADDR20_W-1:0] pc_out,
  output logic [rfl_pkg::FLAG_W-1:0] flag_out,
  output logic [rfl_pkg::DATA_W-1:0] sp_out,
  output logic [rfl_pkg::ADDR20_W-1:0] vector_table_base_out,
  output logic bank_sel_out
);
  import rfl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Registers shared by both banks plus the read data holder
  typedef struct packed {
    logic [DATA_W-1:0] static_base;
    logic [ADDR20_W-1:0] vector_table_base;
    logic [ADDR20_W-1:0] prog_count;
    logic [DATA_W-1:0] user_stack_pointer;
    logic [DATA_W-1:0] interrupt_stack_pointer;
    logic [FLAG_W-1:0] flag_register;
    logic [DATA_W-1:0] sp_active;
    logic [31:0] rdata;
  } rfl_core_s;

  rfl_core_s st_r;
  rfl_core_s st_nxt;

  // Bank write request, steered to the selected bank
  logic a_we;
  logic [SLOT_W-1:0] a_idx;
  logic [1:0] a_be;
  logic [DATA_W-1:0] a_data;
  logic b_we;
  logic [SLOT_W-1:0] b_idx;
  logic [DATA_W-1:0] b_data;

  // Contents of both banks
  logic [BANK_COUNT-1:0][BANK_REGS*DATA_W-1:0] bank_flat;
  // Contents of the bank in use, split by slot
  logic [BANK_REGS-1:0][DATA_W-1:0] cur;

  // Flags from the ALU result
  logic zero_f;
  logic sign_f;
  logic carry_f;
  logic ovf_f;

  // Bank in use
  logic bank_sel;
  // Low byte of the write data, copied to both lanes
  logic [DATA_W-1:0] byte_dup;

  assign bank_sel = st_r.flag_register[FLG_B];
  assign byte_dup = {reg_wdata[7:0], reg_wdata[7:0]};

  // ----------------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------------
  // Two full copies; only the selected bank takes writes
  for (genvar g = 0; g < BANK_COUNT; g++)
  begin : g_bank
    rfl_bank #(
      .N(BANK_REGS),
      .W(DATA_W),
      .XW(SLOT_W)
    ) u_bank (
      .clock(clock),
      .resetn(resetn),
      .a_we(a_we && (bank_sel == 1'(g))), // RULE15
      .a_idx(a_idx),
      .a_be(a_be),
      .a_data(a_data),
      .b_we(b_we && (bank_sel == 1'(g))), // RULE15
      .b_idx(b_idx),
      .b_data(b_data),
      .regs_flat(bank_flat[g])
    );
  end

  // Bank in use feeds reads at once after a switch
  assign cur = bank_flat[bank_sel]; // RULE13

  // ----------------------------------------------------------------------
  // Flag derivation
  // ----------------------------------------------------------------------
  rfl_flag_calc u_flags (
    .result(alu_result),
    .size(alu_size),
    .carry_in(alu_carry),
    .ovf_in(alu_ovf),
    .zero_f(zero_f),
    .sign_f(sign_f),
    .carry_f(carry_f),
    .ovf_f(ovf_f)
  );

  // ----------------------------------------------------------------------
  // Bank write decode
  // ----------------------------------------------------------------------
  // Words, byte halves and 32-bit pairs map to slot writes
  always_comb
  begin
    a_we = 1'b0;
    a_idx = SLOT_D0;
    a_be = BE_BOTH;
    a_data = reg_wdata[15:0];
    b_we = 1'b0;
    b_idx = SLOT_D2;
    b_data = reg_wdata[31:16];
    if (reg_wr)
    begin
      unique case (reg_addr)
        // Whole 16-bit registers of the bank
        IDX_DATA_ZERO, IDX_DATA_ONE, IDX_DATA_TWO, IDX_DATA_THREE:
        begin
          a_we = 1'b1; // RULE1
          a_idx = reg_addr[SLOT_W-1:0];
        end
        IDX_ADDR_FIRST, IDX_ADDR_SECOND:
        begin
          a_we = 1'b1; // RULE3
          a_idx = reg_addr[SLOT_W-1:0];
        end
        IDX_FRAME_BASE:
        begin
          a_we = 1'b1; // RULE4
          a_idx = SLOT_FB;
        end
        // Byte halves of the first two data registers
        IDX_ZERO_LOW:
        begin
          a_we = 1'b1; // RULE1
          a_be = BE_LOW;
          a_data = byte_dup;
        end
        IDX_ZERO_HIGH:
        begin
          a_we = 1'b1; // RULE1
          a_be = BE_HIGH;
          a_data = byte_dup;
        end
        IDX_ONE_LOW:
        begin
          a_we = 1'b1; // RULE1
          a_idx = SLOT_D1;
          a_be = BE_LOW;
          a_data = byte_dup;
        end
        IDX_ONE_HIGH:
        begin
          a_we = 1'b1; // RULE1
          a_idx = SLOT_D1;
          a_be = BE_HIGH;
          a_data = byte_dup;
        end
        // 32-bit pairs, upper register takes the upper half
        IDX_PAIR_LOW32:
        begin
          a_we = 1'b1; // RULE2
          b_we = 1'b1;
        end
        IDX_PAIR_HIGH32:
        begin
          a_we = 1'b1; // RULE2
          a_idx = SLOT_D1;
          b_we = 1'b1;
          b_idx = SLOT_D3;
        end
        IDX_ADDR_PAIR32:
        begin
          a_we = 1'b1; // RULE3
          a_idx = SLOT_A0;
          b_we = 1'b1;
          b_idx = SLOT_A1;
        end
        // Shared registers are handled below
        default:
        begin
          a_we = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Shared registers, flags and read data
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // Counter moves on to the next instruction
    if (pc_adv)
      st_nxt.prog_count = st_r.prog_count + ADDR20_W'(pc_step); // RULE6
    // Port writes; a load of the counter beats an advance
    if (reg_wr)
    begin
      unique case (reg_addr)
        IDX_STATIC_BASE:
          st_nxt.static_base = reg_wdata[15:0]; // RULE4
        IDX_VECTOR_BASE:
          st_nxt.vector_table_base = reg_wdata[19:0]; // RULE5
        IDX_PROG_COUNT:
          st_nxt.prog_count = reg_wdata[19:0]; // RULE6
        IDX_USER_SP:
          st_nxt.user_stack_pointer = reg_wdata[15:0]; // RULE7
        IDX_INTR_SP:
          st_nxt.interrupt_stack_pointer = reg_wdata[15:0]; // RULE7
        IDX_FLAGS:
          st_nxt.flag_register = reg_wdata[10:0]; // RULE8
        IDX_ACTIVE_SP:
        begin
          // Write lands in whichever pointer the flag selects
          if (st_r.flag_register[FLG_U])
            st_nxt.user_stack_pointer = reg_wdata[15:0]; // RULE7
          else
            st_nxt.interrupt_stack_pointer = reg_wdata[15:0]; // RULE7
        end
        default:
        begin
          st_nxt.static_base = st_nxt.static_base;
        end
      endcase
    end
    // ALU outcome overrides the condition bits of a flag write
    if (alu_upd)
    begin
      st_nxt.flag_register[FLG_C] = carry_f; // RULE9
      st_nxt.flag_register[FLG_Z] = zero_f; // RULE11
      st_nxt.flag_register[FLG_S] = sign_f; // RULE12
      st_nxt.flag_register[FLG_O] = ovf_f; // RULE14
    end
    // Active pointer mirror tracks the new flag and pointers
    if (st_nxt.flag_register[FLG_U])
      st_nxt.sp_active = st_nxt.user_stack_pointer; // RULE7
    else
      st_nxt.sp_active = st_nxt.interrupt_stack_pointer; // RULE7
    // Read data stands only in the cycle after a read strobe
    st_nxt.rdata = 32'h00000000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        IDX_DATA_ZERO, IDX_DATA_ONE, IDX_DATA_TWO, IDX_DATA_THREE,
        IDX_ADDR_FIRST, IDX_ADDR_SECOND, IDX_FRAME_BASE:
          st_nxt.rdata = {16'h0000, cur[reg_addr[SLOT_W-1:0]]}; // RULE13
        IDX_STATIC_BASE:
          st_nxt.rdata = {16'h0000, st_r.static_base};
        IDX_VECTOR_BASE:
          st_nxt.rdata = {12'h000, st_r.vector_table_base};
        IDX_PROG_COUNT:
          st_nxt.rdata = {12'h000, st_r.prog_count};
        IDX_USER_SP:
          st_nxt.rdata = {16'h0000, st_r.user_stack_pointer};
        IDX_INTR_SP:
          st_nxt.rdata = {16'h0000, st_r.interrupt_stack_pointer};
        IDX_FLAGS:
          st_nxt.rdata = {21'h000000, st_r.flag_register}; // RULE8
        IDX_ACTIVE_SP:
          st_nxt.rdata = {16'h0000, st_r.sp_active}; // RULE7
        // Byte halves read back in the low byte
        IDX_ZERO_LOW:
          st_nxt.rdata = {24'h000000, cur[SLOT_D0][7:0]}; // RULE1
        IDX_ZERO_HIGH:
          st_nxt.rdata = {24'h000000, cur[SLOT_D0][15:8]}; // RULE1
        IDX_ONE_LOW:
          st_nxt.rdata = {24'h000000, cur[SLOT_D1][7:0]}; // RULE1
        IDX_ONE_HIGH:
          st_nxt.rdata = {24'h000000, cur[SLOT_D1][15:8]}; // RULE1
        // Pairs read with the upper register on top
        IDX_PAIR_LOW32:
          st_nxt.rdata = {cur[SLOT_D2], cur[SLOT_D0]}; // RULE2
        IDX_PAIR_HIGH32:
          st_nxt.rdata = {cur[SLOT_D3], cur[SLOT_D1]}; // RULE2
        IDX_ADDR_PAIR32:
          st_nxt.rdata = {cur[SLOT_A1], cur[SLOT_A0]}; // RULE3
        // Unmapped index reads zero
        default:
          st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r.static_base <= REG16_RESET;
      st_r.vector_table_base <= VECTOR_TABLE_BASE_RESET;
      st_r.prog_count <= PC_RESET;
      st_r.user_stack_pointer <= REG16_RESET;
      st_r.interrupt_stack_pointer <= REG16_RESET;
      st_r.flag_register <= FLG_RESET;
      st_r.sp_active <= REG16_RESET;
      st_r.rdata <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign pc_out = st_r.prog_count;
  assign flag_out = st_r.flag_register;
  assign sp_out = st_r.sp_active;
  assign vector_table_base_out = st_r.vector_table_base;
  assign bank_sel_out = st_r.flag_register[FLG_B];

endmodule : rfl_core

// ### testbench/rfl_alu_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Behavioural ALU standing in for the execution unit
// ----------------------------------------------------------------------
module rfl_alu_model (
  // Clock
  input wire logic clock,
  // Operation request from the bench
  input wire logic go,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire rfl_pkg::rfl_size_e op_size,
  // Outcome towards the register file
  output logic alu_upd,
  output logic [31:0] alu_result,
  output rfl_pkg::rfl_size_e alu_size,
  output logic alu_carry,
  output logic alu_ovf
);
  import rfl_pkg::*;
  int top; // Index of the sign bit for this size
  logic [31:0] mask; // Operand bits that take part
  logic [32:0] sum; // Sum with carry out on top
  // Add the operands at the requested width
  always_comb
  begin
    top = (op_size == RFL_SZ_BYTE) ? 7 : (op_size == RFL_SZ_LONG) ? 31 : 15;
    mask = (32'h1 << (top + 1)) - 32'h1;
    sum = {1'b0, op_a & mask} + {1'b0, op_b & mask};
  end
  // One outcome for one cycle; afterwards the lines carry junk
  always @(posedge clock)
  begin
    alu_upd <= go;
    if (go)
    begin
      alu_result <= sum[31:0];
      alu_size <= op_size;
      alu_carry <= sum[top+1];
      alu_ovf <= (op_a[top] == op_b[top]) && (sum[top] != op_a[top]);
    end
    else
    begin
      alu_result <= ~alu_result;
      alu_carry <= ~alu_carry;
      alu_ovf <= ~alu_ovf;
    end
  end
endmodule : rfl_alu_model

// ### testbench/rfl_core_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Port checks of the register file
// ----------------------------------------------------------------------
module rfl_core_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register access port
  input wire logic [rfl_pkg::IDX_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // ALU flag update
  input wire logic alu_upd,
  input wire logic [31:0] alu_result,
  input wire rfl_pkg::rfl_size_e alu_size,
  input wire logic alu_carry,
  input wire logic alu_ovf,
  // Program counter sequencing
  input wire logic pc_adv,
  input wire logic [2:0] pc_step,
  // Live processor state
  input wire logic [rfl_pkg::ADDR20_W-1:0] pc_out,
  input wire logic [rfl_pkg::FLAG_W-1:0] flag_out,
  input wire logic [rfl_pkg::DATA_W-1:0] sp_out,
  input wire logic [rfl_pkg::ADDR20_W-1:0] vector_table_base_out,
  input wire logic bank_sel_out
);
  import rfl_pkg::*;
  // One clock domain, checks quiet during reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  read_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read cycle");
  pc_advance_a: assert property (pc_adv && !(reg_wr && reg_addr == IDX_PROG_COUNT) |=>
    pc_out == $past(pc_out) + 20'($past(pc_step))) else $error("program counter step wrong");
  pc_hold_a: assert property (!pc_adv && !reg_wr |=> $stable(pc_out))
    else $error("program counter moved without cause");
  carry_ovf_a: assert property (alu_upd |=> flag_out[FLG_C] == $past(alu_carry) &&
    flag_out[FLG_O] == $past(alu_ovf)) else $error("carry or overflow flag wrong");
  zero_word_a: assert property (alu_upd && alu_size == RFL_SZ_WORD |=>
    flag_out[FLG_Z] == ($past(alu_result[15:0]) == 16'h0)) else $error("zero flag wrong");
  sign_byte_a: assert property (alu_upd && alu_size == RFL_SZ_BYTE |=>
    flag_out[FLG_S] == $past(alu_result[7])) else $error("sign flag wrong");
  bank_hold_a: assert property (!(reg_wr && reg_addr == IDX_FLAGS) |=>
    $stable(bank_sel_out)) else $error("bank select moved without a flag write");
  vector_table_base_load_a: assert property (reg_wr && reg_addr == IDX_VECTOR_BASE |=>
    vector_table_base_out == $past(reg_wdata[19:0])) else $error("vector base not loaded");
  flag_load_a: assert property (reg_wr && reg_addr == IDX_FLAGS && !alu_upd |=>
    flag_out == $past(reg_wdata[10:0])) else $error("flag register not loaded");
  sp_load_a: assert property (reg_wr && reg_addr == IDX_ACTIVE_SP |=>
    sp_out == $past(reg_wdata[15:0])) else $error("active stack pointer not loaded");
endmodule : rfl_core_assertions

bind rfl_core rfl_core_assertions i_rfl_core_assertions (.clock, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alu_upd, .alu_result, .alu_size, .alu_carry,
  .alu_ovf, .pc_adv, .pc_step, .pc_out, .flag_out, .sp_out, .vector_table_base_out, .bank_sel_out);

// ### testbench/tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Self-checking bench of the register file
// ----------------------------------------------------------------------
module tb_top;
  import rfl_pkg::*;
  // Optional write, then one read with its expected data
  typedef struct packed {logic wr; logic [4:0] wa; logic [31:0] wd; logic [4:0] ra;
    logic [31:0] exp;} rfl_row_s;
  // ALU operands with expected {O,S,Z,C}
  typedef struct packed {logic [31:0] a; logic [31:0] b; rfl_size_e sz;
    logic [3:0] exp;} rfl_alu_row_s;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pc_adv = 1'b0;
  logic [2:0] pc_step = 3'h0;
  logic go = 1'b0;
  logic [31:0] op_a = 32'h0;
  logic [31:0] op_b = 32'h0;
  rfl_size_e op_size = RFL_SZ_WORD;
  logic [31:0] reg_rdata, alu_result, rd_val;
  logic alu_upd, alu_carry, alu_ovf, bank_sel_out;
  rfl_size_e alu_size;
  logic [19:0] pc_out, vector_table_base_out;
  logic [10:0] flag_out;
  logic [15:0] sp_out;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // Register walk: bank 0, pairs, bytes, bases, stacks, bank 1, unmapped
  rfl_row_s rows [0:24] = '{
    '{1'b1, 5'h00, 32'h00001234, 5'h00, 32'h00001234}, '{1'b1, 5'h01, 32'h0000abcd, 5'h01, 32'h0000abcd},
    '{1'b1, 5'h12, 32'h11112222, 5'h02, 32'h00001111}, '{1'b1, 5'h13, 32'h33334444, 5'h03, 32'h00003333},
    '{1'b1, 5'h0e, 32'h000000a5, 5'h0e, 32'h000000a5}, '{1'b1, 5'h0f, 32'h0000005c, 5'h0f, 32'h0000005c},
    '{1'b1, 5'h10, 32'h00000077, 5'h10, 32'h00000077}, '{1'b1, 5'h11, 32'h00000099, 5'h13, 32'h33339977},
    '{1'b0, 5'h00, 32'h00000000, 5'h12, 32'h11115ca5}, '{1'b1, 5'h14, 32'h77778888, 5'h05, 32'h00007777},
    '{1'b1, 5'h04, 32'h0000aaaa, 5'h14, 32'h7777aaaa}, '{1'b1, 5'h06, 32'h0000fb00, 5'h06, 32'h0000fb00},
    '{1'b1, 5'h07, 32'h00005b00, 5'h07, 32'h00005b00}, '{1'b1, 5'h08, 32'hfff12345, 5'h08, 32'h00012345},
    '{1'b1, 5'h09, 32'h00054321, 5'h09, 32'h00054321}, '{1'b1, 5'h0a, 32'h00001111, 5'h0a, 32'h00001111},
    '{1'b1, 5'h0b, 32'h00002222, 5'h0d, 32'h00002222}, '{1'b1, 5'h0d, 32'h00003333, 5'h0b, 32'h00003333},
    '{1'b1, 5'h0c, 32'h000007fd, 5'h0c, 32'h000007fd}, '{1'b0, 5'h00, 32'h00000000, 5'h0d, 32'h00001111},
    '{1'b0, 5'h00, 32'h00000000, 5'h11, 32'h00000000}, '{1'b1, 5'h02, 32'h0000beef, 5'h12, 32'hbeef0000},
    '{1'b1, 5'h0c, 32'h00000000, 5'h00, 32'h00005ca5}, '{1'b1, 5'h1f, 32'hffffffff, 5'h1f, 32'h00000000},
    '{1'b0, 5'h00, 32'h00000000, 5'h12, 32'h11115ca5}};
  // Flag outcomes at each operand size
  rfl_alu_row_s alus [0:4] = '{'{32'hffff, 32'h1, RFL_SZ_WORD, 4'h3},
    '{32'h7fff, 32'h1, RFL_SZ_WORD, 4'hc}, '{32'h80, 32'h80, RFL_SZ_BYTE, 4'hb},
    '{32'h80000000, 32'h0, RFL_SZ_LONG, 4'h4}, '{32'hffffffff, 32'h1, RFL_SZ_LONG, 4'h3}};

  rfl_core i_rfl_core (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .alu_upd, .alu_result, .alu_size, .alu_carry, .alu_ovf, .pc_adv, .pc_step, .pc_out,
    .flag_out, .sp_out, .vector_table_base_out, .bank_sel_out);
  rfl_alu_model i_rfl_alu_model (.clock, .go, .op_a, .op_b, .op_size, .alu_upd, .alu_result,
    .alu_size, .alu_carry, .alu_ovf);

  // 125 MHz clock
  always #4 clock = ~clock;

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Report and end the run
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // One-cycle write strobe
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr_reg
  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd_reg
  // Ask the ALU model for one outcome and let the flags settle
  task automatic alu_op(input logic [31:0] a, input logic [31:0] b, input rfl_size_e s);
    @(posedge clock);
    go <= 1'b1;
    op_a <= a;
    op_b <= b;
    op_size <= s;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
  endtask : alu_op

  // Hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk({bank_sel_out, flag_out, pc_out}, 32'h0);
    chk({sp_out, vector_table_base_out[15:0]}, 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr_reg(rows[i].wa, rows[i].wd);
      rd_reg(rows[i].ra, rd_val);
      chk(rd_val, rows[i].exp);
    end
    foreach (alus[i])
    begin
      alu_op(alus[i].a, alus[i].b, alus[i].sz);
      chk({28'h0, flag_out[FLG_O], flag_out[FLG_S], flag_out[FLG_Z], flag_out[FLG_C]},
        {28'h0, alus[i].exp});
    end
    // Write then read with no gap, then the idle read data
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= 5'h01;
    reg_wdata <= 32'h5a5a;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 32'h5a5a);
    @(posedge clock);
    #1 chk(reg_rdata, 32'h0);
    // Program counter wraps at 20 bits over back-to-back steps
    wr_reg(5'h09, 32'h000ffffe);
    @(posedge clock);
    pc_adv <= 1'b1;
    pc_step <= 3'h3;
    @(posedge clock);
    pc_step <= 3'h7;
    @(posedge clock);
    pc_adv <= 1'b0;
    #1 chk(32'(pc_out), 32'h00008);
    // A port write of the counter wins over an advance
    @(posedge clock);
    pc_adv <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= 5'h09;
    reg_wdata <= 32'h12345;
    @(posedge clock);
    pc_adv <= 1'b0;
    reg_wr <= 1'b0;
    #1 chk(32'(pc_out), 32'h12345);
    // Flag write and ALU update in one cycle: ALU flags win over written ones
    @(posedge clock);
    go <= 1'b1;
    op_a <= 32'hffff;
    op_b <= 32'h1;
    op_size <= RFL_SZ_WORD;
    @(posedge clock);
    go <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= 5'h0c;
    reg_wdata <= 32'h090;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1 chk(32'(flag_out), 32'h095);
    chk({31'h0, bank_sel_out}, 32'h1);
    chk(32'(sp_out), 32'h1111);
    // Reset in mid-run, then bank 0 and the state read back cleared
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd_reg(5'h12, rd_val);
    chk(rd_val, 32'h0);
    chk({bank_sel_out, flag_out, pc_out}, 32'h0);
    stop_test();
  end
endmodule : tb_top
